// *** design/dstrb_ctrl.sv ***
// Host controller for a 16K x 1 strobed dynamic memory.
// Assumes the memory pins are registered here and delays are board-small.
// Operation
// - Each of 128 rows is refreshed at least every 2 ms.
// - At least 8 refresh cycles after power-up before use.
// - No strobe stays active longer than 10,000 ns.
// - Random cycles start at least 375 ns apart.
// - Row strobe stays inactive at least 100 ns between active periods.
// - Page columns at least 170 ns apart, column high at least 60 ns.
// - Write-enable and data held at least 45 ns after reference edge.
module dstrb_ctrl
	import dstrb_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              srst,
	// User request
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic              req_page,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic              req_data,
	output logic                   req_ready,
	output logic                   rd_valid,
	output logic                   rd_data,
	output logic                   init_done,
	// Memory pins
	output logic                   row_strobe_n,
	output logic                   col_strobe_n,
	output logic                   write_en_n,
	output logic [HALF_W-1:0]      multiplexed_address_inputs,
	output logic                   din,
	input  wire logic              dout
);
	typedef enum logic [6:0] {
		S_IDLE = 7'b000_0001,
		S_ROW  = 7'b000_0010,
		S_COL  = 7'b000_0100,
		S_CWAI = 7'b000_1000,
		S_CPRE = 7'b001_0000,
		S_RHI  = 7'b010_0000,
		S_REF  = 7'b100_0000
	} dstrb_state_e;

	dstrb_tmr_if tmr ();
	dstrb_state_e      st_reg, st_next;
	logic [15:0]       ref_cnt_reg;
	logic [HALF_W-1:0] ref_row_reg;
	logic [3:0]        init_cnt_reg;
	logic              ref_pend_reg;
	logic              wr_reg;
	logic              pg_reg;
	logic [HALF_W-1:0] col_reg;
	logic [HALF_W-1:0] row_reg;
	logic [15:0]       rc_cnt_reg;
	logic [15:0]       ras_cnt_reg;
	logic [2:0]        sync_reg;
	logic              take;
	logic              page_hit;
	logic              ref_due;
	logic              ras_long;
	logic              idle_go;

	dstrb_timer u_tmr (
		.sys_clk (sys_clk),
		.srst    (srst),
		.t       (tmr.tmr)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Page hit only for the same row, while the row may stay open
	assign ref_due  = ref_pend_reg || !init_done;
	assign ras_long = ras_cnt_reg >= 16'(MAXP_CYC - RC_CYC);
	assign page_hit = req_valid && req_page && pg_reg && !ref_due
		&& !ras_long && (req_addr[ADDR_W-1:HALF_W] == row_reg);
	assign take     = req_valid && req_ready;
	// Fresh reset aborts a cycle; still give the row its precharge
	assign idle_go  = tmr.done && (rc_cnt_reg >= 16'(RP_CYC));

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	// Three stages; data counts once second and third agree
	always_ff @(posedge sys_clk) begin
		if (srst)
			sync_reg <= 3'b000;
		else
			sync_reg <= {sync_reg[1:0], dout};
	end

	// ----------------------------------------------------------------
	// Refresh scheduler
	// ----------------------------------------------------------------
	// One row every 2 ms / 128, so all rows are met in time
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ref_cnt_reg  <= 16'h0000;
			ref_pend_reg <= 1'b0;
		end else begin
			if (ref_cnt_reg == 16'(REF_INT_CYC - 1)) begin
				ref_cnt_reg  <= 16'h0000;
				ref_pend_reg <= 1'b1;
			end else begin
				ref_cnt_reg  <= ref_cnt_reg + 16'h0001;
				if (st_reg == S_REF && tmr.done)
					ref_pend_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst)
			st_reg <= S_IDLE;
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			S_IDLE: begin
				if (idle_go && ref_due)
					st_next = S_REF;
				else if (idle_go && req_valid)
					st_next = S_ROW;
			end
			S_ROW:  if (tmr.done) st_next = S_COL;
			S_COL:  if (tmr.done) st_next = S_CWAI;
			S_CWAI: if (tmr.done) st_next = page_hit ? S_CPRE : S_RHI;
			S_CPRE: if (tmr.done) st_next = S_COL;
			S_RHI:  if (tmr.done) st_next = S_IDLE;
			S_REF:  if (tmr.done) st_next = S_IDLE;
			default: st_next = S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Timer loads
	// ----------------------------------------------------------------
	// Each phase loads its own least duration on entry
	// Column stays low past row access time plus two cycles for the input stages
	always_comb begin
		tmr.load  = (st_next != st_reg);
		tmr.value = 16'h0000;
		case (st_next)
			S_ROW:  tmr.value = 16'(RCD_CYC);
			S_COL:  tmr.value = 16'(RAC_CYC - RCD_CYC + 2);
			S_CWAI: tmr.value = 16'h0001;
			S_CPRE: tmr.value = 16'(PC_CYC - CAS_CYC - 2);
			S_RHI:  tmr.value = 16'(RP_CYC);
			S_REF:  tmr.value = 16'(RAS_CYC);
			S_IDLE: tmr.value = (rc_cnt_reg >= 16'(RC_CYC)) ? 16'h0000
				: 16'(RC_CYC) - rc_cnt_reg;
			default: tmr.value = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Cycle and pulse counters
	// ----------------------------------------------------------------
	// Counts from row strobe fall; guards cycle spacing and pulse length
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rc_cnt_reg  <= 16'h0000;
			ras_cnt_reg <= 16'h0000;
		end else begin
			if (st_next == S_ROW || st_next == S_REF)
				rc_cnt_reg <= 16'h0001;
			else if (rc_cnt_reg != 16'hFFFF)
				rc_cnt_reg <= rc_cnt_reg + 16'h0001;
			if (row_strobe_n)
				ras_cnt_reg <= 16'h0000;
			else
				ras_cnt_reg <= ras_cnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Request capture
	// ----------------------------------------------------------------
	// Ready only at a row start or a page column start, so data is held for the whole column
	assign req_ready = ((st_reg == S_IDLE && idle_go && !ref_due)
		|| (st_reg == S_CWAI && tmr.done && page_hit));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_reg  <= 1'b0;
			pg_reg  <= 1'b0;
			col_reg <= 7'h00;
			row_reg <= 7'h00;
			din     <= 1'b0;
		end else if (take) begin
			wr_reg  <= req_write;
			pg_reg  <= req_page;
			col_reg <= req_addr[HALF_W-1:0];
			row_reg <= req_addr[ADDR_W-1:HALF_W];
			din     <= req_data;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Early write only; write-enable low on the same edge the column falls
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			row_strobe_n               <= 1'b1;
			col_strobe_n               <= 1'b1;
			write_en_n                 <= 1'b1;
			multiplexed_address_inputs <= 7'h00;
		end else begin
			row_strobe_n <= !(st_next == S_ROW || st_next == S_COL
				|| st_next == S_CWAI || st_next == S_CPRE
				|| st_next == S_REF);
			col_strobe_n <= !(st_next == S_COL);
			write_en_n   <= !(wr_reg && st_next == S_COL);
			if (st_next == S_REF)
				multiplexed_address_inputs <= ref_row_reg;
			else if (st_next == S_COL)
				multiplexed_address_inputs <= col_reg;
			else if (st_next == S_ROW)
				multiplexed_address_inputs <= req_addr[ADDR_W-1:HALF_W];
		end
	end

	// ----------------------------------------------------------------
	// Refresh row and power-up count
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ref_row_reg  <= 7'h00;
			init_cnt_reg <= 4'h0;
			init_done    <= 1'b0;
		end else if (st_reg == S_REF && tmr.done) begin
			ref_row_reg <= ref_row_reg + 7'h01;
			if (init_cnt_reg != 4'(POWERUP_REFRESHES))
				init_cnt_reg <= init_cnt_reg + 4'h1;
			if (init_cnt_reg == 4'(POWERUP_REFRESHES - 1))
				init_done <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read data return
	// ----------------------------------------------------------------
	// Sample at column end, well past access time, while output holds
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_valid <= 1'b0;
			rd_data  <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (st_reg == S_COL && tmr.done && !wr_reg) begin
				rd_valid <= (sync_reg[2] == sync_reg[1]);
				rd_data  <= sync_reg[2];
			end
		end
	end
endmodule : dstrb_ctrl

// *** design/dstrb_pkg.sv ***
// Constants shared by the strobe-interface memory controller.
// Assumes a single 100 MHz clock and a 16K x 1 strobed dynamic memory.
package dstrb_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 14;
	localparam int HALF_W     = 7;
	localparam int ROW_COUNT  = 128;
	localparam int CLK_NS     = 10;
	// ----------------------------------------------------------------
	// Times in ns and derived cycle counts
	// ----------------------------------------------------------------
	localparam int ROW_ACCESS_TIME_NS      = 150;
	localparam int COLUMN_ACCESS_TIME_NS   = 100;
	localparam int ROW_TO_COLUMN_DELAY_NS  = 20;
	localparam int COLUMN_PULSE_WIDTH_NS   = 100;
	localparam int ROW_PULSE_WIDTH_NS      = 150;
	localparam int ROW_PRECHARGE_TIME_NS   = 100;
	localparam int RANDOM_CYCLE_TIME_NS    = 375;
	localparam int PAGE_CYCLE_TIME_NS      = 170;
	localparam int PAGE_COLUMN_PRECHARGE_NS = 60;
	localparam int WRITE_HOLD_TIME_NS      = 45;
	localparam int INPUT_DATA_HOLD_NS      = 45;
	localparam int MAX_PULSE_NS            = 10000;
	localparam int REFRESH_PERIOD_NS       = 2000000;
	localparam int POWERUP_REFRESHES       = 8;
	// Least times round up
	localparam int RCD_CYC  = (ROW_TO_COLUMN_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_CYC  = (COLUMN_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_CYC  = (ROW_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC   = (ROW_PRECHARGE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_CYC   = (RANDOM_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int PC_CYC   = (PAGE_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_CYC   = (PAGE_COLUMN_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WCH_CYC  = (WRITE_HOLD_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int DH_CYC   = (INPUT_DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAC_CYC  = (ROW_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAC_CYC  = (COLUMN_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	// Longest times round down
	localparam int MAXP_CYC = MAX_PULSE_NS / CLK_NS;
	// Refresh spacing: one row per 2 ms / 128, rounded down
	localparam int REF_INT_CYC = REFRESH_PERIOD_NS / ROW_COUNT / CLK_NS;
	localparam int CNT_W    = 16;
endpackage : dstrb_pkg

// *** design/dstrb_timer.sv ***
// Down counter that paces every strobe phase of the controller.
// Assumes loads come from logic on the same clock.
module dstrb_timer (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// Controller side
	dstrb_tmr_if.tmr  t
);
	logic [15:0] cnt_reg;
	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------
	// Done is high once the loaded number of cycles has passed
	always_ff @(posedge sys_clk) begin
		if (srst)
			cnt_reg <= 16'h0000;
		else if (t.load)
			cnt_reg <= t.value;
		else if (cnt_reg != 16'h0000)
			cnt_reg <= cnt_reg - 16'h0001;
	end
	// Done ignores load, so it never loops back through next-state logic
	assign t.done = (cnt_reg == 16'h0000);
endmodule : dstrb_timer

// *** design/dstrb_tmr_if.sv ***
// Carrier between controller and its wait timer.
// Assumes both ends sit on sys_clk.
interface dstrb_tmr_if;
	logic        load;
	logic [15:0] value;
	logic        done;
	modport ctrl (output load, output value, input done);
	modport tmr  (input load, input value, output done);
endinterface : dstrb_tmr_if

// *** tb/dstrb_ctrl_asserts.sv ***
// Pin timing checks on the strobed memory controller.
// Assumes it is bound onto dstrb_ctrl; one clock domain.
module dstrb_ctrl_asserts
	import dstrb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Observed ports
	input wire logic init_done,
	input wire logic rd_valid,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_en_n,
	input wire logic din
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// --------
	// Counters
	// --------
	logic [7:0]  rfall_reg;
	logic [7:0]  cfall_reg;
	logic [10:0] rlow_reg;
	logic [10:0] clow_reg;
	logic [7:0]  rhi_reg;
	// Saturating gaps, so long idle never wraps into a false hit
	// Reset starts fall gaps full: no earlier fall to be close to
	always_ff @(posedge sys_clk) begin
		rfall_reg <= srst ? 8'hFF : $fell(row_strobe_n) ? 8'h01
			: rfall_reg + {7'h00, rfall_reg != 8'hFF};
		cfall_reg <= srst ? 8'hFF : $fell(col_strobe_n) ? 8'h01
			: cfall_reg + {7'h00, cfall_reg != 8'hFF};
		rhi_reg <= (srst || !row_strobe_n) ? 8'h00
			: rhi_reg + {7'h00, rhi_reg != 8'hFF};
		rlow_reg <= (srst || row_strobe_n) ? 11'h000 : rlow_reg + 11'h001;
		clow_reg <= (srst || col_strobe_n) ? 11'h000 : clow_reg + 11'h001;
	end
	chk_row_pulse_max: assert property (rlow_reg <= MAXP_CYC)
		else $error("row strobe low too long");
	chk_col_pulse_max: assert property (clow_reg <= MAXP_CYC)
		else $error("column strobe low too long");
	chk_row_precharge: assert property ($fell(row_strobe_n) |->
		rhi_reg >= RP_CYC) else $error("row precharge short");
	chk_random_gap: assert property ($fell(row_strobe_n) |->
		rfall_reg >= RC_CYC) else $error("row cycles too close");
	chk_page_gap: assert property ($fell(col_strobe_n) |->
		cfall_reg >= PC_CYC) else $error("column cycles too close");
	chk_col_precharge: assert property ($rose(col_strobe_n) |->
		col_strobe_n[*6]) else $error("column precharge short");
	chk_write_hold: assert property ($fell(col_strobe_n) && !write_en_n
		|-> (!write_en_n && $stable(din))[*5])
		else $error("write enable or data released early");
	chk_init_row_only: assert property (!init_done |-> col_strobe_n)
		else $error("column strobed before start-up refreshes");
	chk_row_then_col: assert property ($fell(col_strobe_n) |->
		!row_strobe_n && !$past(row_strobe_n, 2))
		else $error("column strobe without open row");
	chk_read_at_end: assert property (rd_valid |->
		$rose(col_strobe_n) && write_en_n)
		else $error("read data not taken at column end");
endmodule : dstrb_ctrl_asserts

// *** tb/dstrb_mem_model.sv ***
// Behavioural 16K x 1 strobed memory as the controller's far side.
// Assumes strobes come only from the controller under test.
module dstrb_mem_model
	import dstrb_pkg::*;
(
	// Strobes and write enable
	input wire logic              row_strobe_n,
	input wire logic              col_strobe_n,
	input wire logic              write_en_n,
	// Address and data
	input wire logic [HALF_W-1:0] addr,
	input wire logic              din,
	output logic                  dout
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// Storage
	// --------
	logic              mem [0:(1<<ADDR_W)-1];
	logic [HALF_W-1:0] row_q;
	logic [HALF_W-1:0] col_q;
	logic              rd_q = 1'h0;
	logic              early_q = 1'h0;
	logic              ok_q = 1'h0;
	realtime           row_t;
	realtime           w;
	// Row half latched just after the fall, clear of same-edge updates
	always @(negedge row_strobe_n) begin
		row_t = $realtime;
		#1;
		row_q = addr;
	end
	// Slowest legal answer: later of row and column access limits
	// Write enable within the setup window still counts as early
	always @(negedge col_strobe_n) begin
		#1;
		col_q = addr;
		early_q = !write_en_n;
		if (early_q) mem[{row_q, col_q}] = din;
		rd_q = mem[{row_q, col_q}];
		w = row_t + ROW_ACCESS_TIME_NS - $realtime;
		#(w > COLUMN_ACCESS_TIME_NS ? w : COLUMN_ACCESS_TIME_NS);
		ok_q = !col_strobe_n && !early_q;
	end
	// Column rise turns the output off at once
	always @(posedge col_strobe_n) ok_q = 1'h0;
	// Late write enable stores din; output keeps the read value
	// Waits until the column process has classified the cycle
	always @(negedge write_en_n) begin
		#2;
		if (!col_strobe_n && !early_q) mem[{row_q, col_q}] = din;
	end
	// Off or not yet valid shows the inverse, never a lucky match
	assign dout = ok_q ? rd_q : !rd_q;
endmodule : dstrb_mem_model

// *** tb/testbench.sv ***
// Self-checking bench for the strobed memory controller.
// Assumes the model and checker files are compiled before this one.
module testbench
	import dstrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic w; logic pg; logic [ADDR_W-1:0] a; logic d; logic e;
	} dstrb_row_s;
	logic              sys_clk = 1'h0;
	logic              srst = 1'h1;
	logic              req_valid = 1'h0;
	logic              req_write = 1'h0;
	logic              req_page = 1'h0;
	logic              req_data = 1'h0;
	logic [ADDR_W-1:0] req_addr = 14'h0000;
	logic              req_ready, rd_valid, rd_data, init_done;
	logic              row_n, col_n, we_n, din, dout, used;
	logic [HALF_W-1:0] maddr;
	int                n_mismatch = 0, n_tests = 0, cyc = 0;
	int                n_ref = 0, n_row = 0;
	dstrb_row_s        tbl [12];
	dstrb_ctrl dut (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid),
		.req_write(req_write), .req_page(req_page), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .init_done(init_done), .row_strobe_n(row_n),
		.col_strobe_n(col_n), .write_en_n(we_n),
		.multiplexed_address_inputs(maddr), .din(din), .dout(dout));
	dstrb_mem_model mem (.row_strobe_n(row_n), .col_strobe_n(col_n),
		.write_en_n(we_n), .addr(maddr), .din(din), .dout(dout));
	// --------
	// Clock, monitors, timeout
	// --------
	initial forever #5 sys_clk = ~sys_clk;
	// A row cycle with no column fall is a row-only refresh
	always @(negedge col_n) used = 1'h1;
	always @(negedge row_n) n_row++;
	always @(posedge row_n) begin
		if (used !== 1'h1) n_ref++;
		used = 1'h0;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic cmp(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %b", $realtime, what, got);
		end
	endtask : cmp
	// Held until taken; reads wait for the answer pulse
	task automatic req(input dstrb_row_s r);
		int i;
		req_write = r.w;
		req_page = r.pg;
		req_addr = r.a;
		req_data = r.d;
		req_valid = 1'h1;
		for (i = 0; i < 400 && req_ready !== 1'h1; i++) @(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'h0;
		if (!r.w) begin
			for (i = 0; i < 60 && rd_valid !== 1'h1; i++) @(negedge sys_clk);
			cmp(rd_valid, 1'h1, "read answer");
			cmp(rd_data, r.e, "read data");
		end else
			@(negedge sys_clk); // Valid never drops and rises at once
	endtask : req
	task automatic finish_test();
		if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	// Wait for start-up refreshes to finish
	task automatic wait_init();
		int i;
		n_ref = 0;
		for (i = 0; i < 2000 && init_done !== 1'h1; i++) @(negedge sys_clk);
		cmp(n_ref >= POWERUP_REFRESHES, 1'h1, "start-up refreshes");
	endtask : wait_init
	// --------
	// Sequence
	// --------
	initial begin
		int i, r0;
		tbl = '{'{1'h1, 1'h0, 14'h0000, 1'h1, 1'h0},
			'{1'h1, 1'h0, 14'h3FFF, 1'h0, 1'h0},
			'{1'h1, 1'h0, 14'h2A55, 1'h1, 1'h0},
			'{1'h0, 1'h0, 14'h0000, 1'h0, 1'h1},
			'{1'h0, 1'h0, 14'h3FFF, 1'h0, 1'h0},
			'{1'h0, 1'h0, 14'h2A55, 1'h0, 1'h1},
			'{1'h1, 1'h0, 14'h0000, 1'h0, 1'h0},
			'{1'h0, 1'h0, 14'h0000, 1'h0, 1'h0},
			'{1'h1, 1'h1, 14'h0A80, 1'h1, 1'h0},
			'{1'h1, 1'h1, 14'h0A81, 1'h0, 1'h0},
			'{1'h0, 1'h1, 14'h0A80, 1'h0, 1'h1},
			'{1'h0, 1'h0, 14'h0A81, 1'h0, 1'h0}};
		repeat (4) @(negedge sys_clk);
		srst = 1'h0;
		cmp(row_n & col_n & we_n, 1'h1, "strobes idle");
		cmp(init_done | rd_valid, 1'h0, "reset outputs");
		wait_init();
		for (i = 0; i < 12; i++) begin
			if (i == 8) r0 = n_row;
			req(tbl[i]);
		end
		cmp(n_row - r0 <= 2, 1'h1, "page kept row open");
		// Idle past one refresh interval, then check retention
		r0 = n_ref;
		repeat (REF_INT_CYC + 100) @(negedge sys_clk);
		cmp(n_ref > r0, 1'h1, "refresh while idle");
		req(tbl[4]);
		req(tbl[5]);
		// Reset in mid-request restarts the start-up refreshes
		req_addr = 14'h2A55;
		req_write = 1'h0;
		req_valid = 1'h1;
		repeat (3) @(negedge sys_clk);
		srst = 1'h1;
		repeat (4) @(negedge sys_clk);
		req_valid = 1'h0;
		cmp(init_done, 1'h0, "init cleared");
		srst = 1'h0;
		wait_init();
		req(tbl[0]);
		req(tbl[3]);
		finish_test();
	end
endmodule : testbench
bind dstrb_ctrl dstrb_ctrl_asserts chk (.sys_clk(sys_clk), .srst(srst),
	.init_done(init_done), .rd_valid(rd_valid), .row_strobe_n(row_strobe_n),
	.col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .din(din));
